// [verilog/trsl_consts.vh]
/*
  Constants for the run, error and status logic of the thermoelectric
  controller: register offsets, field positions, reset values, timing.
  Assumes a 100 MHz sys_clk and 32-bit APB with byte addresses.
*/
// Notes on behaviour
// [R1] run pin is low-active with pull-up; low starts regulation and power stage
// [R2] software run mode: final run needs run pin and software start together
// [R3] hardware run mode: software start bypassed, run pin alone decides
// [R4] active error-clear pin clears all latched error states
// [R5] error-clear touches only error latches, never configuration or run state
// [R6] healthy output high-active, held inactive while booting after reset
// [R7] healthy only with no error; any error drops it
// [R8] on-target high-active, active when enabled and within one degree
// [R9] on-target inactive when disabled or outside the one degree window
// [R10] setpoint source defaults to hardware; degrees equal volts times ten
// [R11] temperature voltage output equals degrees divided by ten
// [R12] overcurrent cuts the drive in logic, no software in the path
// [R13] drive polarity follows heating or cooling demand only
// [R14] polarity of digital inputs and outputs is configurable
// [R15] errors: sensor fault, overcurrent, power stage over-temperature
// [R16] run and error-clear pins synchronised and debounced before use
`ifndef TRSL_CONSTS_VH
`define TRSL_CONSTS_VH

`define TRSL_CLK_MHZ        100
`define TRSL_DEBOUNCE_US    100
`define TRSL_BOOT_US        10000
`define TRSL_DEBOUNCE_CYC   (`TRSL_DEBOUNCE_US * `TRSL_CLK_MHZ)
`define TRSL_BOOT_CYC       (`TRSL_BOOT_US * `TRSL_CLK_MHZ)

`define TRSL_ADDR_CTRL      12'h000
`define TRSL_ADDR_POL       12'h004
`define TRSL_ADDR_SWSP      12'h008
`define TRSL_ADDR_STATUS    12'h00c
`define TRSL_ADDR_IRQSTAT   12'h010
`define TRSL_ADDR_IRQMASK   12'h014
`define TRSL_ADDR_TARGET    12'h018

`define TRSL_CTRL_RUNSW     0
`define TRSL_CTRL_START     1
`define TRSL_CTRL_SPSW      2
`define TRSL_CTRL_RST       3'h0

`define TRSL_POL_RUN        0
`define TRSL_POL_CLR        1
`define TRSL_POL_HEALTHY    2
`define TRSL_POL_ONTGT      3
`define TRSL_POL_RST        4'h0

`define TRSL_SWSP_RST       16'h09c4

`define TRSL_IRQ_ERR        0
`define TRSL_IRQ_ONTGT      1
`define TRSL_IRQ_RUN        2
`define TRSL_IRQ_CLR        3

// temperature in hundredths of a degree, voltages in millivolts
`define TRSL_DEG_PER_VOLT   17'h0000a
`define TRSL_UNIT_RATIO     17'h0000a
`define TRSL_WINDOW         17'h00064

`endif

// [verilog/trsl_core.v]
/*
  Run combining, error latching, healthy and on-target indication,
  setpoint selection and scaling, Peltier polarity drive, APB registers.
  Assumes fault and run pins are asynchronous, the ADC codes and loop
  demand come from logic on sys_clk, and the APB master is well behaved.
*/
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`include "trsl_consts.vh"

module trsl_core #(
  parameter [23:0] DEBOUNCE_CYCLES = `TRSL_DEBOUNCE_CYC,
  parameter [23:0] BOOT_CYCLES     = `TRSL_BOOT_CYC
) (
  input  wire        sys_clk,
  input  wire        srst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        hardwareRunInputN,
  input  wire        errorClearInputN,
  input  wire        sensorFaultIn,
  input  wire        overCurrentIn,
  input  wire        overTempIn,
  input  wire [12:0] setpointVoltageIn,
  input  wire [15:0] sensorTempIn,
  input  wire        loopCoolDemand,
  output reg         healthyOutput,
  output reg         onTargetOutput,
  output reg  [12:0] temperatureVoltageOut,
  output reg         peltierDriveA,
  output reg         peltierDriveB,
  output reg         irqOut
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function [15:0] mvToCenti;
    input [12:0] mv;
    reg   [16:0] t;
    begin
      t = ({4'h0, mv} * `TRSL_DEG_PER_VOLT) / `TRSL_UNIT_RATIO;
      mvToCenti = t[15:0];
    end
  endfunction

  function [12:0] centiToMv;
    input [15:0] c;
    reg   [16:0] t;
    begin
      t = ({1'b0, c} * `TRSL_UNIT_RATIO) / `TRSL_DEG_PER_VOLT;
      if (t > 17'h01fff)
        centiToMv = 13'h1fff;
      else
        centiToMv = t[12:0];
    end
  endfunction

  // one-hot register select, used by the write path only; the read mux
  // decodes paddr in a case of its own on the same address constants
  function [6:0] regSelect;
    input [11:0] a;
    begin
      case (a)
        `TRSL_ADDR_CTRL:    regSelect = 7'h01;
        `TRSL_ADDR_POL:     regSelect = 7'h02;
        `TRSL_ADDR_SWSP:    regSelect = 7'h04;
        `TRSL_ADDR_STATUS:  regSelect = 7'h08;
        `TRSL_ADDR_IRQSTAT: regSelect = 7'h10;
        `TRSL_ADDR_IRQMASK: regSelect = 7'h20;
        `TRSL_ADDR_TARGET:  regSelect = 7'h40;
        default:            regSelect = 7'h00;
      endcase
    end
  endfunction

  // window is inclusive at both ends; distance taken without sign so that
  // a reading below and above the setpoint are treated alike
  function withinWindow;
    input [15:0] a;
    input [15:0] b;
    reg   [16:0] d;
    begin
      if (a >= b)
        d = {1'b0, a} - {1'b0, b};
      else
        d = {1'b0, b} - {1'b0, a};
      withinWindow = (d <= `TRSL_WINDOW);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: first stage feeds only the second

  reg  [4:0]  syncA_q;
  reg  [4:0]  syncB_q;
  wire [4:0]  pinRaw;

  assign pinRaw = {overTempIn, overCurrentIn, sensorFaultIn,
                   errorClearInputN, hardwareRunInputN};

  always @(posedge sys_clk) begin
    if (srst) begin
      syncA_q <= 5'h03;
      syncB_q <= 5'h03;
    end else begin
      syncA_q <= pinRaw; // [R16]
      syncB_q <= syncA_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // debounce of run and clear pins; a level must hold for the full count

  reg  [23:0] dbCnt_q [0:1];
  reg  [1:0]  dbLvl_q;
  integer     i;

  always @(posedge sys_clk) begin
    if (srst) begin
      dbLvl_q    <= 2'h3;
      dbCnt_q[0] <= 24'h000000;
      dbCnt_q[1] <= 24'h000000;
    end else begin
      for (i = 0; i < 2; i = i + 1) begin
        if (syncB_q[i] == dbLvl_q[i]) begin
          dbCnt_q[i] <= 24'h000000;
        end else if (dbCnt_q[i] >= DEBOUNCE_CYCLES - 24'h000001) begin
          dbCnt_q[i] <= 24'h000000; // [R16]
          dbLvl_q[i] <= syncB_q[i];
        end else begin
          dbCnt_q[i] <= dbCnt_q[i] + 24'h000001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration registers

  reg  [2:0]  ctrl_q;
  reg  [3:0]  pol_q;
  reg  [15:0] swSetpoint_q;
  reg  [3:0]  irqStat_q;
  reg  [3:0]  irqMask_q;

  // pull-up keeps an open pin high, which the default polarity reads idle
  wire runPinActive   = ~(dbLvl_q[0] ^ pol_q[`TRSL_POL_RUN]);   // [R1] [R14]
  wire clearPinActive = ~(dbLvl_q[1] ^ pol_q[`TRSL_POL_CLR]);   // [R14]

  wire finalRun = ctrl_q[`TRSL_CTRL_RUNSW] ?
                  (runPinActive & ctrl_q[`TRSL_CTRL_START]) :   // [R2]
                  runPinActive;                                 // [R3]

  ////////////////////////////////////////////////////////////////////////
  // boot hold-off

  reg  [23:0] bootCnt_q;
  reg         booting_q;

  always @(posedge sys_clk) begin
    if (srst) begin
      bootCnt_q <= 24'h000000;
      booting_q <= 1'b1;
    end else if (booting_q) begin
      if (bootCnt_q >= BOOT_CYCLES - 24'h000001)
        booting_q <= 1'b0; // [R6]
      else
        bootCnt_q <= bootCnt_q + 24'h000001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // error latches; a fault still present wins over the clear

  reg  [2:0]  err_q;
  wire [2:0]  faultNow = syncB_q[4:2]; // [R15]
  wire        anyError = (|err_q) | (|faultNow);

  always @(posedge sys_clk) begin
    if (srst)
      err_q <= 3'h0;
    else if (clearPinActive)
      err_q <= faultNow;              // [R4] [R5]
    else
      err_q <= err_q | faultNow;      // [R15]
  end

  ////////////////////////////////////////////////////////////////////////
  // setpoint, window and indication

  wire [15:0] targetCenti = ctrl_q[`TRSL_CTRL_SPSW] ? swSetpoint_q :
                            mvToCenti(setpointVoltageIn);       // [R10]
  wire        onTarget    = finalRun &
                            withinWindow(sensorTempIn, targetCenti); // [R8] [R9]
  wire        healthy     = ~booting_q & ~anyError;             // [R6] [R7]
  reg         onTargetPrev_q;
  reg         runPrev_q;
  reg         errPrev_q;
  reg         clrPrev_q;

  always @(posedge sys_clk) begin
    if (srst) begin
      healthyOutput         <= 1'b0;
      onTargetOutput        <= 1'b0;
      temperatureVoltageOut <= 13'h0000;
      peltierDriveA         <= 1'b0;
      peltierDriveB         <= 1'b0;
      onTargetPrev_q        <= 1'b0;
      runPrev_q             <= 1'b0;
      errPrev_q             <= 1'b0;
      clrPrev_q             <= 1'b0;
    end else begin
      healthyOutput  <= healthy ^ pol_q[`TRSL_POL_HEALTHY];      // [R7] [R14]
      onTargetOutput <= onTarget ^ pol_q[`TRSL_POL_ONTGT];       // [R9] [R14]
      temperatureVoltageOut <= centiToMv(sensorTempIn);          // [R11]
      // overcurrent sync path gates the drive directly, one cycle later
      if (finalRun & ~anyError & ~booting_q) begin
        peltierDriveA <= ~loopCoolDemand;                        // [R13]
        peltierDriveB <= loopCoolDemand;                         // [R13]
      end else begin
        peltierDriveA <= 1'b0;                                   // [R12]
        peltierDriveB <= 1'b0;
      end
      onTargetPrev_q <= onTarget;
      runPrev_q      <= finalRun;
      errPrev_q      <= anyError;
      clrPrev_q      <= clearPinActive;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt events

  wire [3:0] irqEvent;
  assign irqEvent[`TRSL_IRQ_ERR]   = anyError & ~errPrev_q;
  assign irqEvent[`TRSL_IRQ_ONTGT] = onTarget & ~onTargetPrev_q;
  assign irqEvent[`TRSL_IRQ_RUN]   = finalRun ^ runPrev_q;
  assign irqEvent[`TRSL_IRQ_CLR]   = clearPinActive & ~clrPrev_q;

  ////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, answer registered

  wire        accessReq = psel & penable & ~pready;
  wire        commitWr  = psel & penable & pready & pwrite & ~pslverr;
  // decode is taken from the held address; the master keeps it stable
  // through the access phase, so the commit edge sees the same select
  wire [6:0]  regSel    = regSelect(paddr);
  reg  [31:0] rdMux;
  reg         addrHit;

  always @* begin
    rdMux   = 32'h00000000;
    addrHit = 1'b1;
    case (paddr)
      `TRSL_ADDR_CTRL:    rdMux = {29'h0, ctrl_q};
      `TRSL_ADDR_POL:     rdMux = {28'h0, pol_q};
      `TRSL_ADDR_SWSP:    rdMux = {16'h0, swSetpoint_q};
      `TRSL_ADDR_STATUS:  rdMux = {25'h0, booting_q, err_q, onTarget,
                                   healthy, finalRun};
      `TRSL_ADDR_IRQSTAT: rdMux = {28'h0, irqStat_q};
      `TRSL_ADDR_IRQMASK: rdMux = {28'h0, irqMask_q};
      `TRSL_ADDR_TARGET:  rdMux = {16'h0, targetCenti};
      default:            addrHit = 1'b0;
    endcase
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (accessReq) begin
      pready  <= 1'b1;
      pslverr <= ~addrHit;
      prdata  <= pwrite ? 32'h00000000 : rdMux;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      ctrl_q       <= `TRSL_CTRL_RST;
      pol_q        <= `TRSL_POL_RST;
      swSetpoint_q <= `TRSL_SWSP_RST;
      irqMask_q    <= 4'h0;
    end else if (commitWr) begin
      // read-only words ignore the write; upper data bits are dropped
      if (regSel[0])
        ctrl_q       <= pwdata[2:0];
      if (regSel[1])
        pol_q        <= pwdata[3:0];
      if (regSel[2])
        swSetpoint_q <= pwdata[15:0];
      if (regSel[5])
        irqMask_q    <= pwdata[3:0];
    end
  end

  // a new event in the clearing cycle survives the write of one
  always @(posedge sys_clk) begin
    if (srst) begin
      irqStat_q <= 4'h0;
      irqOut    <= 1'b0;
    end else begin
      if (commitWr && regSel[4])
        irqStat_q <= (irqStat_q & ~pwdata[3:0]) | irqEvent;
      else
        irqStat_q <= irqStat_q | irqEvent;
      irqOut <= |(irqStat_q & irqMask_q);
    end
  end

endmodule // trsl_core

// [bench/trsl_core_properties.sv]
/*
  Pin level checks on trsl_core.
  Assumes default polarity and sim counts of 4 and 8.
*/
`timescale 1ns/100ps
module trsl_core_properties #(
  parameter [23:0] DEBOUNCE_CYCLES = 24'h4,
  parameter [23:0] BOOT_CYCLES     = 24'h8
) (
  input wire        sys_clk,
  input wire        srst,
  input wire        hardwareRunInputN,
  input wire        sensorFaultIn,
  input wire        overCurrentIn,
  input wire        overTempIn,
  input wire [15:0] sensorTempIn,
  input wire        healthyOutput,
  input wire        onTargetOutput,
  input wire [12:0] temperatureVoltageOut,
  input wire        peltierDriveA,
  input wire        peltierDriveB
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  wire driveOff = !peltierDriveA && !peltierDriveB;
  // an open pin must outlast sync, debounce and the output stage
  sequence s_runOpen; hardwareRunInputN [*8]; endsequence
  sequence s_ocHeld; overCurrentIn [*4]; endsequence
//////////////////////////////////////////////////////////////////////////////
  AST_BOOT: assert property ($fell(srst) |-> !healthyOutput [*7])
    else $error("healthy during boot");
  AST_SENSOR: assert property (sensorFaultIn [*5] |-> !healthyOutput)
    else $error("healthy with sensor fault");
  AST_HOT: assert property (overTempIn [*5] |-> !healthyOutput)
    else $error("healthy with hot stage");
  AST_OC_CUT: assert property (s_ocHeld |-> driveOff)
    else $error("drive kept on overcurrent");
  AST_POLARITY: assert property (!(peltierDriveA && peltierDriveB))
    else $error("both drive sides on");
  AST_RUN_OFF: assert property (s_runOpen |=> driveOff)
    else $error("drive on with run pin open");
  AST_TGT_OFF: assert property (s_runOpen |=> !onTargetOutput)
    else $error("on target while disabled");
  AST_TEMP_OUT: assert property (!$past(srst) &&
    $past(sensorTempIn) < 16'h1fff |->
    {3'h0, temperatureVoltageOut} == $past(sensorTempIn))
    else $error("temperature output off");
endmodule // trsl_core_properties

// [bench/trsl_far_side.sv]
/*
  Run and error-clear contacts to ground on the far side.
  Assumes the bench moves them right after a rising edge.
*/
`timescale 1ns/100ps
module trsl_far_side (
  input  wire  sys_clk,
  input  wire  runClosed,
  input  wire  clrClosed,
  output logic hardwareRunInputN,
  output logic errorClearInputN
);
  // an open contact reads high through the pull-up
  initial begin
    hardwareRunInputN = 1'b1;
    errorClearInputN  = 1'b1;
  end
  always @(posedge sys_clk) begin
    hardwareRunInputN <= !runClosed;
    errorClearInputN  <= !clrClosed;
  end
endmodule // trsl_far_side

// [bench/testbench.sv]
/*
  Self-checking bench for trsl_core.
  Assumes counts of 4 and 8 and default pin polarity.
*/
`timescale 1ns/100ps
`include "trsl_consts.vh"
module testbench;
  logic        sys_clk = 1'b0, srst = 1'b1, err;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, rd;
  logic        runClosed = 1'b0, clrClosed = 1'b0, loopCoolDemand = 1'b0;
  logic        sensorFaultIn = 1'b0, overCurrentIn = 1'b0, overTempIn = 1'b0;
  logic [12:0] setpointVoltageIn = 13'h09c4;
  logic [15:0] sensorTempIn = 16'h0;
  logic [3:0]  rp = 4'hb;
  wire  [31:0] prdata;
  wire  [12:0] temperatureVoltageOut;
  wire         pready, pslverr, hardwareRunInputN, errorClearInputN;
  wire         healthyOutput, onTargetOutput, peltierDriveA, peltierDriveB;
  wire         irqOut;
  int          n_fail = 0, num_checks = 0, sp, d, i;
  int          offs[4] = '{-101, -100, 100, 101};
  int          cv[4] = '{1, 3, 3, 0};
  trsl_core #(.DEBOUNCE_CYCLES(24'h4), .BOOT_CYCLES(24'h8)) DUT (
    .sys_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .hardwareRunInputN, .errorClearInputN,
    .sensorFaultIn, .overCurrentIn, .overTempIn, .setpointVoltageIn,
    .sensorTempIn, .loopCoolDemand, .healthyOutput, .onTargetOutput,
    .temperatureVoltageOut, .peltierDriveA, .peltierDriveB, .irqOut);
  trsl_far_side u_far (.sys_clk, .runClosed, .clrClosed,
    .hardwareRunInputN, .errorClearInputN);
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
//////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] dt);
    int k;
    k = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dt;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) n_fail++;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  function automatic logic expTgt(input int t, s, input logic run);
    return run && (t - s <= 100) && (s - t <= 100);
  endfunction
  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    #20000;
    n_fail++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'h93e9));
    cyc(6);
    srst <= 1'b0;
    apb(1'b0, `TRSL_ADDR_SWSP, 32'h0);
    check("swsp", 32'h09c4, rd);
    apb(1'b0, 12'h100, 32'h0);
    check("unmapped", 32'h1, err);
    $display("test registers done");
    runClosed <= 1'b1;
    for (i = 0; i < 8; i++) begin
      sp = $urandom_range(4000, 200);
      d = offs[i % 4];
      setpointVoltageIn <= 13'(sp);
      sensorTempIn <= 16'(sp + d);
      loopCoolDemand <= i[0];
      cyc(12);
      check("ontgt", expTgt(sp + d, sp, 1'b1), onTargetOutput);
      check("driveA", !i[0], peltierDriveA);
      check("tout", 32'(sp + d), temperatureVoltageOut);
    end
    apb(1'b0, `TRSL_ADDR_TARGET, 32'h0);
    check("target", 32'(sp), rd);
    $display("test window done");
    for (i = 0; i < 4; i++) begin
      apb(1'b1, `TRSL_ADDR_CTRL, cv[i]);
      runClosed <= rp[i];
      cyc(12);
      check("run", rp[i] && (!cv[i][0] || cv[i][1]),
            peltierDriveA || peltierDriveB);
    end
    apb(1'b1, `TRSL_ADDR_SWSP, 32'h0bb8);
    apb(1'b1, `TRSL_ADDR_CTRL, 32'h4);
    apb(1'b0, `TRSL_ADDR_TARGET, 32'h0);
    check("swtarget", 32'h0bb8, rd);
    $display("test run source done");
    check("irqmask", 32'h0, irqOut);
    apb(1'b1, `TRSL_ADDR_IRQMASK, 32'h1);
    for (i = 0; i < 3; i++) begin
      {overTempIn, overCurrentIn, sensorFaultIn} <= 3'(1 << i);
      cyc(6);
      {overTempIn, overCurrentIn, sensorFaultIn} <= 3'h0;
      apb(1'b0, `TRSL_ADDR_STATUS, 32'h0);
      check("latch", 32'(1 << (i + 3)), rd & 32'h38);
      check("healthy", 32'h0, healthyOutput);
      check("irq", 32'h1, irqOut);
      clrClosed <= 1'b1;
      cyc(2);
      clrClosed <= 1'b0;
      cyc(10);
      check("glitch", 32'h0, healthyOutput);
      clrClosed <= 1'b1;
      cyc(12);
      clrClosed <= 1'b0;
      cyc(12);
      check("cleared", 32'h1, healthyOutput);
      apb(1'b1, `TRSL_ADDR_IRQSTAT, 32'h1);
      cyc(2);
      check("irqoff", 32'h0, irqOut);
    end
    apb(1'b0, `TRSL_ADDR_CTRL, 32'h0);
    check("ctrlkept", 32'h4, rd);
    $display("test errors done");
    end_of_test();
  end
endmodule // testbench
bind trsl_core trsl_core_properties #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES),
  .BOOT_CYCLES(BOOT_CYCLES)) u_props (.sys_clk, .srst, .hardwareRunInputN,
  .sensorFaultIn, .overCurrentIn, .overTempIn, .sensorTempIn,
  .healthyOutput, .onTargetOutput, .temperatureVoltageOut,
  .peltierDriveA, .peltierDriveB);
